/* File: pkg/rops_pkg.sv */
// Package with register map, field layout and reset values of the output pin selector.
package rops_pkg;
    localparam int unsigned ROPS_NUM_PINS = 10;
    localparam int unsigned ROPS_NUM_REGS = 5;
    localparam int unsigned ROPS_SEL_W = 6;
    localparam int unsigned ROPS_NUM_FUNCS = 64;
    localparam int unsigned ROPS_ADDR_W = 5;
    localparam logic [4:0] ROPS_OFF_MAP01 = 5'h00;
    localparam logic [4:0] ROPS_OFF_MAP23 = 5'h04;
    localparam logic [4:0] ROPS_OFF_MAP45 = 5'h08;
    localparam logic [4:0] ROPS_OFF_MAP67 = 5'h0C;
    localparam logic [4:0] ROPS_OFF_MAP89 = 5'h10;
    localparam int unsigned ROPS_EVEN_LSB = 0;
    localparam int unsigned ROPS_ODD_LSB = 8;
    localparam int unsigned ROPS_ABSENT_PIN = 5;
    localparam logic [15:0] ROPS_MAP_MASK = 16'h3F3F;
    localparam logic [15:0] ROPS_MAP_RESET = 16'h0000;
    localparam logic [5:0] ROPS_SEL_RESET = 6'h00;
    localparam logic [1:0] ROPS_RESP_OKAY = 2'h0;
    localparam logic [1:0] ROPS_RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/rops_pin_mux.sv */
// One remappable pin: selects one peripheral output by function number.
`timescale 1ns/1ps
module rops_pin_mux #(
    parameter int unsigned NUM_FUNCS = 64,
    parameter int unsigned SEL_W = 6
) (
    input wire logic [NUM_FUNCS-1:0] func_i,
    input wire logic [SEL_W-1:0] sel_i,
    output logic pin_o
);
    always_comb begin
        pin_o = func_i[sel_i];
    end
endmodule

/* File: hdl/rops_top.sv */
// Remappable output pin selector with AXI4-Lite register access.
`timescale 1ns/1ps
module rops_top #(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter int unsigned NUM_FUNCS = 64
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [rops_pkg::ROPS_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [rops_pkg::ROPS_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [NUM_FUNCS-1:0] periph_out_i,
    output logic [rops_pkg::ROPS_NUM_PINS-1:0] remappable_pin_o
);
    import rops_pkg::*;

    // Maps a byte address to a register index; returns valid flag.
    function automatic logic [3:0] decode(input logic [ROPS_ADDR_W-1:0] addr);
        logic [3:0] res;
        res = 4'h0;
        unique case (addr)
            ROPS_OFF_MAP01: res = 4'h8;
            ROPS_OFF_MAP23: res = 4'h9;
            ROPS_OFF_MAP45: res = 4'hA;
            ROPS_OFF_MAP67: res = 4'hB;
            ROPS_OFF_MAP89: res = 4'hC;
            default: res = 4'h0;
        endcase
        return res;
    endfunction

    logic [ROPS_SEL_W-1:0] sel_q [ROPS_NUM_PINS];
    logic [ROPS_SEL_W-1:0] sel_d [ROPS_NUM_PINS];
    logic [15:0] map_word [ROPS_NUM_REGS];

    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [ROPS_ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [1:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [ROPS_NUM_PINS-1:0] pin_q, pin_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic do_write;
    logic [3:0] wdec, rdec;

    // Assembles the readable image of each mapping register.
    always_comb begin
        for (int r = 0; r < ROPS_NUM_REGS; r++) begin
            map_word[r] = ROPS_MAP_RESET;
            map_word[r][ROPS_EVEN_LSB +: ROPS_SEL_W] = sel_q[2*r];
            map_word[r][ROPS_ODD_LSB +: ROPS_SEL_W] = sel_q[2*r+1];
            map_word[r] = map_word[r] & ROPS_MAP_MASK;
        end
    end

    // Write channel acceptance; address and data may arrive in either order.
    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid_i && !aw_got_q) begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_got_q) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata_i[15:0];
            wstrb_d = s_axi_wstrb_i[1:0];
        end
        if (do_write) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wdec[3] ? ROPS_RESP_OKAY : ROPS_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        awready_d = !aw_got_d;
        wready_d = !w_got_d;
    end

    assign do_write = aw_got_q && w_got_q && !bvalid_q;
    assign wdec = decode(awaddr_q);

    // Selection field updates with byte-lane strobes.
    always_comb begin
        for (int p = 0; p < ROPS_NUM_PINS; p++) begin
            sel_d[p] = sel_q[p];
        end
        if (do_write && wdec[3]) begin
            for (int r = 0; r < ROPS_NUM_REGS; r++) begin
                if (wdec[2:0] == 3'(r)) begin
                    if (wstrb_q[0]) begin
                        sel_d[2*r] = wdata_q[ROPS_EVEN_LSB +: ROPS_SEL_W];
                    end
                    if (wstrb_q[1]) begin
                        sel_d[2*r+1] = wdata_q[ROPS_ODD_LSB +: ROPS_SEL_W];
                    end
                end
            end
        end
        if (SMALL_PACKAGE) begin
            sel_d[ROPS_ABSENT_PIN] = ROPS_SEL_RESET;
        end
    end

    // Read channel.
    assign rdec = decode(s_axi_araddr_i);
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid_i && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d = 32'h00000000;
            rresp_d = ROPS_RESP_SLVERR;
            if (rdec[3]) begin
                rdata_d = {16'h0000, map_word[rdec[2:0]]};
                rresp_d = ROPS_RESP_OKAY;
            end
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d;
    end

    // Pin muxes.
    logic [ROPS_NUM_PINS-1:0] mux_out;
    for (genvar g = 0; g < ROPS_NUM_PINS; g++) begin : g_pin
        rops_pin_mux #(
            .NUM_FUNCS(NUM_FUNCS),
            .SEL_W(ROPS_SEL_W)
        ) u_mux (
            .func_i(periph_out_i),
            .sel_i(sel_q[g]),
            .pin_o(mux_out[g])
        );
        AST_PIN_ROUTE: assert property (@(posedge clk_i) disable iff (!nrst_i)
            $past(nrst_i) |-> pin_q[g] == $past(periph_out_i[sel_q[g]]))
            else $error("Pin not driven from its selected output.");
    end
    assign pin_d = mux_out;

    // Write channel registers.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= '0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
            bvalid_q <= 1'b0;
            bresp_q <= ROPS_RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // Selection field registers.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int p = 0; p < ROPS_NUM_PINS; p++) begin
                sel_q[p] <= ROPS_SEL_RESET;
            end
        end else begin
            sel_q <= sel_d;
        end
    end

    // Read channel registers.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
            rdata_q <= 32'h00000000;
            rresp_q <= ROPS_RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            arready_q <= arready_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Pin output registers.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_q <= '0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign remappable_pin_o = pin_q;

    // Checks.
    AST_PIN_FOLLOWS_SEL: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(nrst_i) |-> pin_q[0] == $past(periph_out_i[sel_q[0]]))
        else $error("Pin 0 not from selected output.");
    AST_ODD_FIELD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        do_write && wdec == 4'h8 && wstrb_q[1] |=> sel_q[1] == $past(wdata_q[13:8]))
        else $error("Odd field not written from bits 13:8.");
    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_rvalid_o |-> (s_axi_rdata_o & 32'hFFFFC0C0) == 32'h00000000)
        else $error("Reserved read bits not zero.");
    AST_PIN5_ABSENT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        SMALL_PACKAGE |-> sel_q[ROPS_ABSENT_PIN] == ROPS_SEL_RESET)
        else $error("Absent pin 5 field holds a value.");
    AST_PIN0_WRITE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        do_write && wdec == 4'h8 && wstrb_q[0] |=> sel_q[0] == $past(wdata_q[5:0]))
        else $error("Pin 0 field not written from bits 5:0.");
    AST_RESET_CLEAR: assert property (@(posedge clk_i)
        $rose(nrst_i) |-> map_word[0] == ROPS_MAP_RESET && map_word[4] == ROPS_MAP_RESET)
        else $error("Mapping not clear after reset.");
    AST_BRESP_AFTER: assert property (@(posedge clk_i) disable iff (!nrst_i)
        do_write |=> s_axi_bvalid_o) else $error("Write response missing.");
    AST_READ_ANSWER: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("Read not answered.");
    AST_EVEN_LAST: assert property (@(posedge clk_i) disable iff (!nrst_i)
        do_write && wdec == 4'hC && wstrb_q[0] |=> sel_q[8] == $past(wdata_q[5:0]))
        else $error("Pin 8 field not written from bits 5:0.");
    AST_ODD_LAST: assert property (@(posedge clk_i) disable iff (!nrst_i)
        do_write && wdec == 4'hC && wstrb_q[1] |=> sel_q[9] == $past(wdata_q[13:8]))
        else $error("Pin 9 field not written from bits 13:8.");
    AST_ODD_KEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        do_write && wdec == 4'h9 && !wstrb_q[1] |=> sel_q[3] == $past(sel_q[3]))
        else $error("Odd field changed without its byte strobe.");
    AST_READ_ODD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_arvalid_i && s_axi_arready_o && rdec == 4'hB
        |=> s_axi_rdata_o[13:8] == $past(sel_q[7]))
        else $error("Pin 7 field not read from bits 13:8.");
    AST_READ_IMAGE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_arvalid_i && s_axi_arready_o && rdec == 4'h8
        |=> s_axi_rdata_o == {16'h0000, 2'h0, $past(sel_q[1]), 2'h0, $past(sel_q[0])})
        else $error("First mapping register read image wrong.");
    AST_PIN5_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
        SMALL_PACKAGE && s_axi_arvalid_i && s_axi_arready_o && rdec == 4'hA
        |=> s_axi_rdata_o[13:8] == 6'h00)
        else $error("Absent pin 5 field not read as zero.");
    AST_SLVERR_READ: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_arvalid_i && s_axi_arready_o && !rdec[3]
        |=> s_axi_rdata_o == 32'h00000000 && s_axi_rresp_o == ROPS_RESP_SLVERR)
        else $error("Unmapped read not refused with zero data.");
    AST_BVALID_DROP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("Write response not retired.");
    AST_RVALID_DROP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("Read response not retired.");
    AST_RESET_PINS: assert property (@(posedge clk_i)
        $rose(nrst_i) |-> pin_q == '0 && sel_q[9] == ROPS_SEL_RESET)
        else $error("Pins or last field not clear after reset.");
    COV_WRITE: cover property (@(posedge clk_i) disable iff (!nrst_i) do_write && wdec[3]);
    COV_BAD_WRITE: cover property (@(posedge clk_i) disable iff (!nrst_i) do_write && !wdec[3]);
    COV_ODD_ONLY: cover property (@(posedge clk_i) disable iff (!nrst_i) do_write && wstrb_q == 2'h2);
    COV_READ: cover property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_rvalid_o && rresp_q == ROPS_RESP_OKAY);
    COV_BAD_READ: cover property (@(posedge clk_i) disable iff (!nrst_i)
        s_axi_rvalid_o && rresp_q == ROPS_RESP_SLVERR);
endmodule

/* File: tb/rops_top_tb_top.sv */
// Self-checking bench for the remappable output pin selector.
`timescale 1ns/1ps
module rops_top_tb_top;
    import rops_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [63:0] periph = 64'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [9:0] pins;
    logic [9:0] pins_s;
    logic [1:0] rresp_s;
    logic [31:0] rdata_s;
    logic [33:0] rq[$];
    logic [33:0] rsq[$];
    logic [1:0] bq[$];
    logic [15:0] shd [5] = '{default: 16'h0};
    int err_count = 0;
    int total_checks = 0;
    int seed = 32'h08F2;

    always #10 clk_i = ~clk_i;

    rops_top #(.SMALL_PACKAGE(1'b0), .NUM_FUNCS(64)) i_rops_top (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .periph_out_i(periph), .remappable_pin_o(pins)
    );

    rops_top #(.SMALL_PACKAGE(1'b1), .NUM_FUNCS(64)) i_rops_top_small (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(), .s_axi_bresp_o(),
        .s_axi_bvalid_o(), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(),
        .s_axi_rdata_o(rdata_s), .s_axi_rresp_o(rresp_s), .s_axi_rvalid_o(),
        .s_axi_rready_i(rready), .periph_out_i(periph), .remappable_pin_o(pins_s)
    );

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Responses are compared against the oldest expectation noted by the driver.
    always @(posedge clk_i) begin
        if (nrst_i && bvalid && bready) begin
            chk(34'(bresp), 34'(bq.pop_front()));
        end
        if (nrst_i && rvalid && rready) begin
            chk({rresp, rdata}, rq.pop_front());
            chk({rresp_s, rdata_s}, rsq.pop_front());
        end
    end

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        logic ar_done;
        ar_done = 1'b0;
        rq.push_back(e);
        rsq.push_back((a == ROPS_OFF_MAP45) ? (e & ~34'h0_0000_3F00) : e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (!ar_done && arready) begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wreg(input int k, input logic [31:0] d, input logic [3:0] s);
        if (s[0]) shd[k][5:0] = d[5:0];
        if (s[1]) shd[k][13:8] = d[13:8];
        wr(5'(4 * k), d, s, ROPS_RESP_OKAY);
    endtask

    task automatic rdall;
        for (int k = 0; k < 5; k++) rd(5'(4 * k), {ROPS_RESP_OKAY, 16'h0, shd[k]});
    endtask

    task automatic pin_chk;
        logic [5:0] s;
        periph <= {$random(seed), $random(seed)};
        repeat (3) @(posedge clk_i);
        for (int k = 0; k < 10; k++) begin
            s = (k % 2) ? shd[k / 2][13:8] : shd[k / 2][5:0];
            chk(34'(pins[k]), 34'(periph[s]));
            chk(34'(pins_s[k]), 34'(periph[(k == ROPS_ABSENT_PIN) ? 6'h00 : s]));
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rdall();
        pin_chk();
        for (int k = 0; k < 5; k++) wreg(k, 32'hFFFF_FFFF, 4'hF);
        rdall();
        for (int n = 0; n < 6; n++) begin
            for (int k = 0; k < 5; k++) wreg(k, $random(seed), 4'(n % 3 + 1));
            rdall();
            pin_chk();
        end
        for (int n = 0; n < 64; n++) begin
            wreg(n % 5, 32'(n * 257), 4'h3);
            pin_chk();
        end
        wr(5'h14, 32'h0000_0101, 4'h3, ROPS_RESP_SLVERR);
        rd(5'h14, {ROPS_RESP_SLVERR, 32'h0});
        rd(5'h1C, {ROPS_RESP_SLVERR, 32'h0});
        rdall();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        shd = '{default: 16'h0};
        @(posedge clk_i);
        rdall();
        pin_chk();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        report_and_stop();
    end
endmodule
